// ### sim/ahs_drive_model.sv
`timescale 1ns/1ps
// ---------------------------------------------------------------
// pulse-input drive: axis with near-point dog, zero grid, stopper
// ---------------------------------------------------------------
module ahs_drive_model #(
	parameter int DOG_LO = 6,
	parameter int DOG_HI = 8,
	parameter int ZERO_GRID = 4,
	parameter int STOP_AT = 30
) (
	input wire logic clock,
	input wire logic pulse,
	input wire logic dir_fwd,
	input wire logic rezero,
	output logic dog,
	output logic zero,
	output int pos,
	output int first_gap,
	output int last_gap
);
	int cyc = 0;
	int last = 0;
	int npulse = 0;
	int zhold = 0;
	int nxt;

	function automatic int mag(input int v);
		return (v < 0) ? -v : v;
	endfunction

	// dog level depends on mechanical position only, either direction
	assign dog = (mag(pos) >= DOG_LO) && (mag(pos) <= DOG_HI);
	// zero held a few cycles so the input synchroniser cannot miss it
	assign zero = (zhold != 0);

	always @(posedge clock) begin
		cyc <= cyc + 1;
		if (zhold != 0) begin
			zhold <= zhold - 1;
		end
		if (rezero) begin
			pos <= 0;
			npulse <= 0;
		end else if (pulse) begin
			nxt = dir_fwd ? pos + 1 : pos - 1;
			// the stopper blocks travel; pulses past it are lost
			if (mag(nxt) > STOP_AT) begin
				nxt = pos;
			end
			if (nxt != pos && nxt % ZERO_GRID == 0) begin
				zhold <= 5;
			end
			pos <= nxt;
			if (npulse == 1) begin
				first_gap <= cyc - last;
			end
			last_gap <= cyc - last;
			last <= cyc;
			npulse <= npulse + 1;
		end
	end
endmodule

// ### sim/axis_homing_sequencer_bench.sv
`timescale 1ns/1ps
module axis_homing_sequencer_bench;
	// ---------------------------------------------------------------
	// signals
	// ---------------------------------------------------------------
	logic CLOCK = 1'b0;
	logic RESET_N = 1'b0;
	logic START = 1'b0;
	ahs_pkg::ahs_ret_type RET_TYPE = ahs_pkg::AHS_RET_MACHINE;
	ahs_pkg::ahs_cfg_type CFG = '0;
	logic DOG;
	logic ZERO;
	logic PULSE;
	logic DIR_FWD;
	logic BUSY;
	logic DONE;
	logic HOME_REQUIRED;
	logic START_REFUSED;
	logic signed [31:0] POSITION;
	logic rezero = 1'b0;
	int m_pos;
	int first_gap;
	int last_gap;
	int bad_count = 0;
	int total_checks = 0;

	initial forever #5 CLOCK = ~CLOCK;

	ahs_homing dut (.CLOCK(CLOCK), .RESET_N(RESET_N), .START(START),
		.RET_TYPE(RET_TYPE), .CFG(CFG), .DOG(DOG), .ZERO(ZERO),
		.PULSE(PULSE), .DIR_FWD(DIR_FWD), .BUSY(BUSY), .DONE(DONE),
		.HOME_REQUIRED(HOME_REQUIRED), .START_REFUSED(START_REFUSED),
		.POSITION(POSITION));

	ahs_drive_model axis (.clock(CLOCK), .pulse(PULSE), .dir_fwd(DIR_FWD),
		.rezero(rezero), .dog(DOG), .zero(ZERO), .pos(m_pos),
		.first_gap(first_gap), .last_gap(last_gap));

	// ---------------------------------------------------------------
	// tasks
	// ---------------------------------------------------------------
	task automatic chk(input bit ok, input string msg);
		total_checks++;
		if (!ok) begin
			bad_count++;
			$display("CHECK FAILED at %0t: %s", $time, msg);
		end
	endtask

	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", total_checks, bad_count);
		if (bad_count == 0 && total_checks > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	// one homing request, then wait for completion under a bound
	task automatic go(input ahs_pkg::ahs_ret_type rt, input logic dir,
		input int exp, input logic signed [31:0] addr);
		int i;
		START = 1'b1;
		RET_TYPE = rt;
		@(negedge CLOCK);
		START = 1'b0;
		@(negedge CLOCK);
		chk(BUSY === 1'b1 && DIR_FWD === dir, "busy or direction");
		for (i = 0; i < 60000 && DONE !== 1'b1; i++) @(negedge CLOCK);
		if (DONE !== 1'b1) begin
			chk(1'b0, "no completion");
			tally_and_finish();
		end else begin
			chk(POSITION === addr && BUSY === 1'b0, "feed position");
			chk(m_pos == exp, "stop point");
			$display("test done: type %0d stop %0d", rt, m_pos);
		end
	endtask

	task automatic machine(input ahs_pkg::ahs_method_type m,
		input logic fwd, input logic [30:0] post, input int exp);
		@(negedge CLOCK);
		rezero = 1'b1;
		CFG.method = m;
		CFG.forward = fwd;
		CFG.post_dog = post;
		@(negedge CLOCK);
		rezero = 1'b0;
		go(ahs_pkg::AHS_RET_MACHINE, fwd, exp, 32'sh00000064);
	endtask

	task automatic refuse(input ahs_pkg::ahs_ret_type rt);
		logic seen;
		logic moved;
		int i;
		seen = 1'b0;
		moved = 1'b0;
		@(negedge CLOCK);
		START = 1'b1;
		RET_TYPE = rt;
		@(negedge CLOCK);
		START = 1'b0;
		for (i = 0; i < 3; i++) begin
			if (START_REFUSED === 1'b1) seen = 1'b1;
			if (BUSY !== 1'b0) moved = 1'b1;
			@(negedge CLOCK);
		end
		chk(seen && !moved, "start not refused");
		$display("test done: refusal of type %0d", rt);
	endtask

	// ---------------------------------------------------------------
	// sequence
	// ---------------------------------------------------------------
	initial begin
		CFG.method = ahs_pkg::AHS_DOG;
		CFG.forward = 1'b1;
		CFG.origin_addr = 32'sh00000064;
		CFG.standby_addr = 32'sh0000005f;
		CFG.home_speed = 18'h30d40;
		CFG.creep_speed = 18'h186a0;
		CFG.accel_ms = 15'h0000;
		repeat (10) @(negedge CLOCK);
		chk(HOME_REQUIRED === 1'b1 && BUSY === 1'b0, "reset state");
		RESET_N = 1'b1;
		refuse(ahs_pkg::AHS_RET_FAST_ORIGIN);
		refuse(ahs_pkg::AHS_RET_FAST_STANDBY);
		CFG.method = ahs_pkg::AHS_NONE;
		refuse(ahs_pkg::AHS_RET_MACHINE);
		repeat (1000) @(negedge CLOCK);
		chk(m_pos == 0 && HOME_REQUIRED === 1'b1, "idle motion");
		machine(ahs_pkg::AHS_DOG, 1'b1, 31'h0, 12);
		chk(first_gap == 500 && last_gap == 1000, "creep change");
		chk(HOME_REQUIRED === 1'b0, "flag kept");
		machine(ahs_pkg::AHS_DOG, 1'b0, 31'h0, -12);
		machine(ahs_pkg::AHS_STOP1, 1'b1, 31'h0, 6);
		machine(ahs_pkg::AHS_STOP2, 1'b1, 31'h0, 8);
		machine(ahs_pkg::AHS_STOP3, 1'b1, 31'h0, 4);
		machine(ahs_pkg::AHS_CNT1, 1'b1, 31'h9, 16);
		machine(ahs_pkg::AHS_CNT2, 1'b1, 31'h5, 11);
		CFG.method = ahs_pkg::AHS_STOP3;
		@(negedge CLOCK);
		go(ahs_pkg::AHS_RET_FAST_STANDBY, 1'b0, 6, 32'sh0000005f);
		@(negedge CLOCK);
		go(ahs_pkg::AHS_RET_FAST_ORIGIN, 1'b1, 11, 32'sh00000064);
		RESET_N = 1'b0;
		repeat (10) @(negedge CLOCK);
		RESET_N = 1'b1;
		chk(HOME_REQUIRED === 1'b1 && POSITION === '0, "reset again");
		refuse(ahs_pkg::AHS_RET_FAST_ORIGIN);
		tally_and_finish();
	end
endmodule

// ### src/ahs_homing.sv
`timescale 1ns/1ps
module ahs_homing (
	input wire logic CLOCK,
	input wire logic RESET_N,
	input wire logic START,
	input wire ahs_pkg::ahs_ret_type RET_TYPE,
	input wire ahs_pkg::ahs_cfg_type CFG,
	input wire logic DOG,
	input wire logic ZERO,
	output logic PULSE,
	output logic DIR_FWD,
	output logic BUSY,
	output logic DONE,
	output logic HOME_REQUIRED,
	output logic START_REFUSED,
	output logic signed [31:0] POSITION
);
	// ---------------------------------------------------------------
	// state
	// ---------------------------------------------------------------
	typedef struct packed {
		ahs_pkg::ahs_state_type st;
		logic [1:0] dog_sync;
		logic [1:0] zero_sync;
		ahs_pkg::ahs_sense_type sense;
		logic [17:0] speed;
		logic [17:0] target_speed;
		logic [16:0] ms_cnt;
		logic [15:0] ms_left;
		logic [15:0] dwell_left;
		logic dwell_run;
		logic [30:0] travel;
		logic dog_seen_off;
		logic dir_fwd;
		logic signed [31:0] pos;
		logic signed [31:0] fast_target;
		logic homed;
		logic home_req;
		logic busy;
		logic done;
		logic refused;
	} ahs_core_type;

	ahs_core_type s_reg;
	ahs_core_type s_next;
	logic step;
	logic ms_tick;
	logic dog_rise;
	logic dog_fall;
	logic zero_rise;
	logic [17:0] run_rate;

	// ---------------------------------------------------------------
	// step generator
	// ---------------------------------------------------------------
	assign run_rate = !s_reg.busy ? 18'h00000 :
		(s_reg.speed > ahs_pkg::SPEED_MAX) ? ahs_pkg::SPEED_MAX :
		(s_reg.speed == 18'h00000) ? ahs_pkg::SPEED_MIN : s_reg.speed;

	ahs_pulse_gen u_pulse (
		.CLOCK(CLOCK),
		.RESET_N(RESET_N),
		.rate(run_rate),
		.step(step)
	);

	// edges read only the second synchroniser stage and its follower
	assign dog_rise = s_reg.dog_sync[1] & ~s_reg.sense.dog;
	assign dog_fall = ~s_reg.dog_sync[1] & s_reg.sense.dog;
	assign zero_rise = s_reg.zero_sync[1] & ~s_reg.sense.zero;
	assign ms_tick = (s_reg.ms_cnt ==
		ahs_pkg::CYC_PER_MS_W'(ahs_pkg::CYC_PER_MS - 1));

	// ---------------------------------------------------------------
	// next state
	// ---------------------------------------------------------------
	always_comb begin
		logic [17:0] step_sz;
		s_next = s_reg;
		step_sz = 18'h00000;
		s_next.dog_sync = {s_reg.dog_sync[0], DOG};
		s_next.zero_sync = {s_reg.zero_sync[0], ZERO};
		s_next.sense.dog = s_reg.dog_sync[1];
		s_next.sense.zero = s_reg.zero_sync[1];
		s_next.ms_cnt = ms_tick ? '0 : s_reg.ms_cnt + 17'h00001;
		s_next.done = 1'b0;
		s_next.refused = 1'b0;
		if (step && s_reg.busy) begin
			s_next.pos = s_reg.dir_fwd ? s_reg.pos + 32'sd1 :
				s_reg.pos - 32'sd1;
			if (s_reg.st == ahs_pkg::ST_DECEL || s_reg.st == ahs_pkg::ST_CREEP ||
				s_reg.st == ahs_pkg::ST_WAIT_ZERO) begin
				s_next.travel = s_reg.travel + 31'h00000001;
			end
		end
		if (s_reg.dwell_run && ms_tick && s_reg.dwell_left != 16'h0000) begin
			s_next.dwell_left = s_reg.dwell_left - 16'h0001;
		end
		if (ms_tick && s_reg.ms_left != 16'h0000) begin
			s_next.ms_left = s_reg.ms_left - 16'h0001;
		end
		// linear ramp toward target, one unit per ms while ms_left runs; once it is zero a fall jumps to target, a rise drops one per clock to 0 then wraps to target
		if ((ms_tick || s_reg.ms_left == 16'h0000) &&
			s_reg.speed != s_reg.target_speed) begin
			step_sz = (s_reg.ms_left == 16'h0000) ? 18'h3ffff : 18'h00001;
			if (s_reg.speed > s_reg.target_speed) begin
				s_next.speed = (s_reg.speed - s_reg.target_speed > step_sz) ?
					s_reg.speed - step_sz : s_reg.target_speed;
			end else begin
				s_next.speed = s_reg.speed + step_sz;
				if (s_next.speed > s_reg.target_speed) begin
					s_next.speed = s_reg.target_speed;
				end
			end
		end
		unique case (s_reg.st)
			ahs_pkg::ST_IDLE: begin
				if (START) begin
					if (RET_TYPE == ahs_pkg::AHS_RET_MACHINE &&
						CFG.method != ahs_pkg::AHS_NONE) begin
						s_next.busy = 1'b1;
						s_next.dir_fwd = CFG.forward;
						s_next.travel = '0;
						s_next.dog_seen_off = 1'b0;
						s_next.dwell_run = 1'b0;
						s_next.speed = ahs_pkg::SPEED_MIN;
						s_next.ms_left = {1'b0, CFG.accel_ms};
						if (CFG.method == ahs_pkg::AHS_STOP3) begin
							s_next.target_speed = CFG.creep_speed;
							s_next.st = ahs_pkg::ST_CREEP;
						end else begin
							s_next.target_speed = CFG.home_speed;
							s_next.st = ahs_pkg::ST_SEEK;
						end
					end else if (RET_TYPE != ahs_pkg::AHS_RET_MACHINE &&
						s_reg.homed) begin
						s_next.busy = 1'b1;
						s_next.fast_target =
							(RET_TYPE == ahs_pkg::AHS_RET_FAST_ORIGIN) ?
							CFG.origin_addr : CFG.standby_addr;
						s_next.speed = ahs_pkg::SPEED_MIN;
						s_next.target_speed = CFG.home_speed;
						s_next.ms_left = {1'b0, CFG.accel_ms};
						s_next.st = ahs_pkg::ST_FAST_RUN;
					end else begin
						s_next.refused = 1'b1;
					end
				end
			end
			ahs_pkg::ST_FAST_RUN: begin
				s_next.dir_fwd = (s_reg.fast_target > s_reg.pos);
				if (s_reg.pos == s_reg.fast_target) begin
					s_next.st = ahs_pkg::ST_FAST_STOP;
				end
			end
			ahs_pkg::ST_SEEK: begin
				if (dog_rise) begin
					s_next.target_speed = CFG.creep_speed;
					s_next.ms_left = {1'b0, CFG.accel_ms};
					s_next.travel = '0;
					s_next.dwell_left = CFG.dwell_ms;
					s_next.dwell_run = (CFG.method == ahs_pkg::AHS_STOP1);
					s_next.st = ahs_pkg::ST_DECEL;
				end
			end
			ahs_pkg::ST_DECEL: begin
				if (s_reg.speed == s_reg.target_speed) begin
					s_next.st = ahs_pkg::ST_CREEP;
				end
			end
			ahs_pkg::ST_CREEP: begin
				if (dog_fall) begin
					s_next.dog_seen_off = 1'b1;
				end
				unique case (CFG.method)
					ahs_pkg::AHS_DOG: begin
						if (s_reg.dog_seen_off || dog_fall) begin
							s_next.st = ahs_pkg::ST_WAIT_ZERO;
						end
					end
					ahs_pkg::AHS_STOP1: begin
						if (s_reg.dwell_left == 16'h0000) begin
							s_next.st = ahs_pkg::ST_DONE;
						end
					end
					ahs_pkg::AHS_STOP2, ahs_pkg::AHS_STOP3: begin
						if (zero_rise) begin
							s_next.st = ahs_pkg::ST_DONE;
						end
					end
					ahs_pkg::AHS_CNT1: begin
						if (s_reg.travel >= CFG.post_dog) begin
							s_next.st = ahs_pkg::ST_WAIT_ZERO;
						end
					end
					ahs_pkg::AHS_CNT2: begin
						if (s_reg.travel >= CFG.post_dog) begin
							s_next.target_speed = ahs_pkg::SPEED_MIN;
							s_next.ms_left = {1'b0, CFG.decel_stop_ms};
							s_next.st = ahs_pkg::ST_STOP_RAMP;
						end
					end
					default: begin
						s_next.st = ahs_pkg::ST_DONE;
					end
				endcase
			end
			ahs_pkg::ST_WAIT_ZERO: begin
				if (zero_rise) begin
					s_next.st = ahs_pkg::ST_DONE;
				end
			end
			ahs_pkg::ST_STOP_RAMP: begin
				// no zero check: count 2 ends on the timed ramp
				if (s_reg.ms_left == 16'h0000 ||
					s_reg.speed == s_reg.target_speed) begin
					s_next.st = ahs_pkg::ST_DONE;
				end
			end
			ahs_pkg::ST_FAST_STOP, ahs_pkg::ST_DONE: begin
				s_next.busy = 1'b0;
				s_next.done = 1'b1;
				s_next.st = ahs_pkg::ST_IDLE;
				if (s_reg.st == ahs_pkg::ST_DONE) begin
					s_next.homed = 1'b1;
					s_next.home_req = 1'b0;
					s_next.pos = CFG.origin_addr;
					s_next.dwell_run = 1'b0;
				end
			end
			default: begin
				s_next.busy = 1'b0;
				s_next.st = ahs_pkg::ST_IDLE;
			end
		endcase
	end

	// ---------------------------------------------------------------
	// registers
	// ---------------------------------------------------------------
	always_ff @(posedge CLOCK or negedge RESET_N) begin
		if (!RESET_N) begin
			s_reg <= '0;
			s_reg.st <= ahs_pkg::ST_IDLE;
			s_reg.home_req <= 1'b1;
		end else begin
			s_reg <= s_next;
		end
	end

	// ---------------------------------------------------------------
	// outputs
	// ---------------------------------------------------------------
	assign PULSE = step & s_reg.busy;
	assign DIR_FWD = s_reg.dir_fwd;
	assign BUSY = s_reg.busy;
	assign DONE = s_reg.done;
	assign HOME_REQUIRED = s_reg.home_req;
	assign START_REFUSED = s_reg.refused;
	assign POSITION = s_reg.pos;

	// ---------------------------------------------------------------
	// checks
	// ---------------------------------------------------------------
	default clocking @(posedge CLOCK); endclocking
	default disable iff (!RESET_N);
	property p_start_machine;
		(s_reg.st == ahs_pkg::ST_IDLE && START &&
		RET_TYPE == ahs_pkg::AHS_RET_MACHINE &&
		CFG.method != ahs_pkg::AHS_NONE) |=> BUSY;
	endproperty
	a_start_machine: assert property (p_start_machine)
		else $error("machine homing did not start");
	property p_home_req;
		$fell(HOME_REQUIRED) |-> $past(s_reg.st) == ahs_pkg::ST_DONE;
	endproperty
	a_home_req: assert property (p_home_req)
		else $error("homing request dropped without completion");
	property p_fast_needs_home;
		(s_reg.st == ahs_pkg::ST_IDLE && START && !s_reg.homed &&
		RET_TYPE != ahs_pkg::AHS_RET_MACHINE) |=> !BUSY && START_REFUSED;
	endproperty
	a_fast_needs_home: assert property (p_fast_needs_home)
		else $error("fast homing accepted before origin");
	property p_dog_decel;
		(s_reg.st == ahs_pkg::ST_SEEK && dog_rise) |=>
		s_reg.target_speed == CFG.creep_speed;
	endproperty
	a_dog_decel: assert property (p_dog_decel)
		else $error("no slowdown on dog");
	sequence s_zero_wait;
		s_reg.st == ahs_pkg::ST_WAIT_ZERO && zero_rise;
	endsequence
	property p_zero_stop;
		s_zero_wait |=> ##1 (!BUSY && DONE);
	endproperty
	a_zero_stop: assert property (p_zero_stop)
		else $error("no stop at zero pulse");
	property p_load_origin;
		(s_reg.st == ahs_pkg::ST_DONE) |=> POSITION == $past(CFG.origin_addr);
	endproperty
	a_load_origin: assert property (p_load_origin)
		else $error("origin not loaded");
	property p_dwell_stop;
		(s_reg.st == ahs_pkg::ST_CREEP && CFG.method == ahs_pkg::AHS_STOP1 &&
		s_reg.dwell_left == 16'h0000) |=> ##1 (!BUSY && DONE);
	endproperty
	a_dwell_stop: assert property (p_dwell_stop)
		else $error("no stop after dwell time");
	property p_dir;
		(PULSE && s_reg.st != ahs_pkg::ST_DONE) |=>
		POSITION == ($past(DIR_FWD) ? $past(POSITION) + 32'sd1 :
		$past(POSITION) - 32'sd1);
	endproperty
	a_dir: assert property (p_dir)
		else $error("position moved against direction");
endmodule

// ### src/ahs_pkg.sv
package ahs_pkg;

	// ---------------------------------------------------------------
	// timing
	// ---------------------------------------------------------------
	localparam int CLK_HZ = 100000000;
	localparam int MS_NS = 1000000;
	localparam int CLK_NS = 10;
	localparam int CYC_PER_MS = MS_NS / CLK_NS;
	localparam int CYC_PER_MS_W = 17;

	// ---------------------------------------------------------------
	// parameter ranges and reset values
	// ---------------------------------------------------------------
	localparam logic [14:0] ACCEL_MS_DEF = 15'h03e8;
	localparam logic [14:0] ACCEL_MS_MAX = 15'h7fff;
	localparam logic [30:0] POST_DOG_MAX = 31'h7fffffff;
	localparam logic [17:0] SPEED_MAX = 18'h30d40;
	localparam logic [17:0] SPEED_MIN = 18'h00001;
	localparam logic [31:0] PHASE_FULL = 32'h05f5e100;

	// ---------------------------------------------------------------
	// homing methods and return types
	// ---------------------------------------------------------------
	typedef enum logic [2:0] {
		AHS_DOG = 3'h0,
		AHS_STOP1 = 3'h1,
		AHS_STOP2 = 3'h2,
		AHS_STOP3 = 3'h3,
		AHS_CNT1 = 3'h4,
		AHS_CNT2 = 3'h5,
		AHS_NONE = 3'h6
	} ahs_method_type;

	typedef enum logic [1:0] {
		AHS_RET_MACHINE = 2'h0,
		AHS_RET_FAST_ORIGIN = 2'h1,
		AHS_RET_FAST_STANDBY = 2'h2
	} ahs_ret_type;

	typedef enum logic [8:0] {
		ST_IDLE = 9'h001,
		ST_FAST_RUN = 9'h002,
		ST_SEEK = 9'h004,
		ST_DECEL = 9'h008,
		ST_CREEP = 9'h010,
		ST_WAIT_ZERO = 9'h020,
		ST_STOP_RAMP = 9'h040,
		ST_FAST_STOP = 9'h080,
		ST_DONE = 9'h100
	} ahs_state_type;

	// shared homing configuration, one set for every axis
	typedef struct packed {
		ahs_method_type method;
		logic forward;
		logic signed [31:0] origin_addr;
		logic signed [31:0] standby_addr;
		logic [17:0] home_speed;
		logic [17:0] creep_speed;
		logic [14:0] accel_ms;
		logic [14:0] decel_stop_ms;
		logic [30:0] post_dog;
		logic [15:0] dwell_ms;
	} ahs_cfg_type;

	// sampled sensor inputs
	typedef struct packed {
		logic dog;
		logic zero;
	} ahs_sense_type;

endpackage

// ### src/ahs_pulse_gen.sv
`timescale 1ns/1ps
// rate generator: phase accumulator emits one step per overflow
module ahs_pulse_gen (
	input wire logic CLOCK,
	input wire logic RESET_N,
	input wire logic [17:0] rate,
	output logic step
);
	typedef struct packed {
		logic [31:0] acc;
		logic step;
	} ahs_pg_type;

	ahs_pg_type s_reg;
	ahs_pg_type s_next;

	always_comb begin
		logic [32:0] sum;
		sum = {1'b0, s_reg.acc} + {15'h0000, rate};
		s_next = s_reg;
		s_next.step = 1'b0;
		if (sum >= {1'b0, ahs_pkg::PHASE_FULL}) begin
			s_next.acc = sum[31:0] - ahs_pkg::PHASE_FULL;
			s_next.step = (rate != 18'h00000);
		end else begin
			s_next.acc = sum[31:0];
		end
	end

	always_ff @(posedge CLOCK or negedge RESET_N) begin
		if (!RESET_N) begin
			s_reg <= '0;
		end else begin
			s_reg <= s_next;
		end
	end

	assign step = s_reg.step;
endmodule
